// ---- logic/i2ccfg_slave.sv ----
// two-wire config slave with working registers and non-volatile shadow
// Summary of operation
// - after start, a 00001xxx byte is not acked and enables high-speed mode.
// - after repeated start normal protocol runs; stop leaves high-speed mode.
// - reads of unmapped register indices return zero.
// - each accepted byte is acked by holding SDA low through ninth clock.
// - register updates on the SCL fall ending the data byte ack.
// - slave address is 11101 plus two address strap bits.
// - index byte is decoded in full; the control register sits at index FFh.
// - at power-up working registers load from the non-volatile store.
// - writing C0h to the control register saves working into the store.
// - a store write of ILIM with bit 7 set locks it; later saves and store writes are refused.
// - reads are always served; write-protect never blocks reads.
// - control register routes accesses to working or store; resets zero.
// - config bit 7 restores defaults and pulses the converter off.
// - enable field picks pins, auto, pass-through or shutdown.
// - config bit 4 ignores writes and reads zero.
// - pin function bit picks reset/fault pin or mode-select input.
// - spread bit enables modulation during fixed-frequency switching.
// - mode field picks pins, PFM auto, forced PWM or select-dependent.
// - only seven-bit addressing; no ten-bit or general call.
module i2ccfg_slave
  import i2ccfg_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  input  wire logic [1:0]  ADDR_STRAP_I,
  input  wire logic [7:0]  STATUS_FLAGS_I,
  output i2ccfg_misc_t     MISC_CONFIG_O,
  output logic [7:0]       BOOST_FLOOR_THRESHOLD_O,
  output logic [7:0]       BOOST_ROOF_THRESHOLD_O,
  output logic [7:0]       CURRENT_LIMIT_SETUP_O,
  output logic             CONVERTER_OFF_O,
  output logic             HS_MODE_O,
  output logic             NVM_LOCKED_O
);
  typedef enum logic [2:0] {
    I2CCFG_IDLE  = 3'h0,
    I2CCFG_RECV  = 3'h1,
    I2CCFG_ACK   = 3'h2,
    I2CCFG_SEND  = 3'h3,
    I2CCFG_MACK  = 3'h4
  } i2ccfg_state_t;

  typedef enum logic [1:0] {
    I2CCFG_B_ADDR = 2'h0,
    I2CCFG_B_IDX  = 2'h1,
    I2CCFG_B_DATA = 2'h2
  } i2ccfg_byte_t;

  logic          scl;
  logic          scl_rise;
  logic          scl_fall;
  logic          sda;
  logic          sda_rise;
  logic          sda_fall;
  logic          start_ev;
  logic          stop_ev;
  i2ccfg_state_t state_ff;
  i2ccfg_byte_t  which_ff;
  logic [7:0]    shift_ff;
  logic [2:0]    bitc_ff;
  logic          rw_ff;
  logic [7:0]    idx_ff;
  logic          hs_ff;
  logic          ack_pend_ff;
  logic          sda_oe_ff;
  i2ccfg_wr_t    wr_ff;
  logic [7:0]    work_ff [1:4];
  logic [7:0]    nvm_ff  [1:4];
  logic [7:0]    nvm_ctrl_ff;
  logic          wp_ff;
  logic [3:0]    load_cnt_ff;
  logic [3:0]    off_cnt_ff;
  logic          use_nvm;
  logic [7:0]    rd_byte;
  logic [7:0]    rx_byte;
  logic          addr_hit;
  logic          hs_code;

  i2ccfg_sync u_scl (
    .CLK_I  (CLK_I),
    .RST_I  (RST_I),
    .pin_i  (SCL_I),
    .lvl_o  (scl),
    .rise_o (scl_rise),
    .fall_o ()
  );
  i2ccfg_sync u_sda (
    .CLK_I  (CLK_I),
    .RST_I  (RST_I),
    .pin_i  (SDA_I),
    .lvl_o  (sda),
    .rise_o (sda_rise),
    .fall_o (sda_fall)
  );

  // strap and status pins come from outside this clock: two stages first
  logic [9:0] pins_meta_ff;
  logic [1:0] strap_ff;
  logic [7:0] status_ff;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pins_meta_ff <= 10'h000;
      strap_ff     <= 2'h0;
      status_ff    <= 8'h00;
    end else begin
      pins_meta_ff          <= {ADDR_STRAP_I, STATUS_FLAGS_I};
      {strap_ff, status_ff} <= pins_meta_ff;
    end
  end

  // scl falls are taken from the synchronised level to stay aligned with sda
  logic scl_last_ff;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_last_ff <= 1'b1;
    end else begin
      scl_last_ff <= scl;
    end
  end
  assign scl_fall = scl_last_ff & ~scl;
  assign start_ev = scl & scl_last_ff & sda_fall;
  assign stop_ev  = scl & scl_last_ff & sda_rise;

  assign rx_byte  = {shift_ff[6:0], sda};
  assign addr_hit = (rx_byte[7:1] == {SLV_ADDR_HI, strap_ff});
  assign hs_code  = (rx_byte[7:3] == HS_CODE_HI);
  assign use_nvm  = (nvm_ctrl_ff == NVM_SEL_NVM);

  // read mux, reachable in any state and regardless of write-protect
  always_comb begin
    rd_byte = ZERO_BYTE;
    if (idx_ff == OFS_NVM_CTRL) begin
      rd_byte = nvm_ctrl_ff;
    end else if (idx_ff == OFS_STATUS) begin
      rd_byte = status_ff;
    end else if (idx_ff >= OFS_MISC_CONFIG && idx_ff <= OFS_ILIM) begin
      rd_byte = use_nvm ? nvm_ff[idx_ff[2:0]] : work_ff[idx_ff[2:0]];
    end
  end

  // bus protocol engine
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff    <= I2CCFG_IDLE;
      which_ff    <= I2CCFG_B_ADDR;
      shift_ff    <= ZERO_BYTE;
      bitc_ff     <= 3'h0;
      rw_ff       <= 1'b0;
      idx_ff      <= ZERO_BYTE;
      hs_ff       <= 1'b0;
      ack_pend_ff <= 1'b0;
      sda_oe_ff   <= 1'b0;
      wr_ff       <= '0;
    end else begin
      wr_ff.wr <= 1'b0;
      if (stop_ev) begin
        state_ff  <= I2CCFG_IDLE;
        sda_oe_ff <= 1'b0;
        hs_ff     <= 1'b0;
      end else if (start_ev) begin
        state_ff  <= I2CCFG_RECV;
        which_ff  <= I2CCFG_B_ADDR;
        bitc_ff   <= 3'h0;
        sda_oe_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          I2CCFG_IDLE: begin
            sda_oe_ff <= 1'b0;
          end
          I2CCFG_RECV: begin
            if (scl_rise) begin
              shift_ff <= rx_byte;
              bitc_ff  <= bitc_ff + 3'h1;
              if (bitc_ff == 3'h7) begin
                ack_pend_ff <= 1'b1;
                unique case (which_ff)
                  I2CCFG_B_ADDR: begin
                    rw_ff <= rx_byte[0];
                    if (hs_code) begin
                      hs_ff       <= 1'b1;
                      ack_pend_ff <= 1'b0;
                      state_ff    <= I2CCFG_IDLE;
                    end else if (!addr_hit) begin
                      ack_pend_ff <= 1'b0;
                      state_ff    <= I2CCFG_IDLE;
                    end
                  end
                  I2CCFG_B_IDX: idx_ff <= rx_byte;
                  default: ;
                endcase
              end
            end else if (scl_fall && ack_pend_ff) begin
              ack_pend_ff <= 1'b0;
              sda_oe_ff   <= 1'b1;
              state_ff    <= I2CCFG_ACK;
            end
          end
          I2CCFG_ACK: begin
            if (scl_fall) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= I2CCFG_RECV;
              unique case (which_ff)
                I2CCFG_B_ADDR: begin
                  which_ff <= I2CCFG_B_IDX;
                  if (rw_ff) begin
                    shift_ff  <= rd_byte;
                    sda_oe_ff <= ~rd_byte[7];
                    state_ff  <= I2CCFG_SEND;
                  end
                end
                I2CCFG_B_IDX: which_ff <= I2CCFG_B_DATA;
                default: begin
                  wr_ff.wr   <= 1'b1;
                  wr_ff.idx  <= idx_ff;
                  wr_ff.data <= shift_ff;
                  which_ff   <= I2CCFG_B_IDX;
                  state_ff   <= I2CCFG_IDLE;
                end
              endcase
            end
          end
          I2CCFG_SEND: begin
            if (scl_fall) begin
              bitc_ff <= bitc_ff + 3'h1;
              if (bitc_ff == 3'h7) begin
                sda_oe_ff <= 1'b0;
                state_ff  <= I2CCFG_MACK;
              end else begin
                shift_ff  <= {shift_ff[6:0], 1'b0};
                sda_oe_ff <= ~shift_ff[6];
              end
            end
          end
          I2CCFG_MACK: begin
            // master nack ends the read; ack sends the same index again
            if (scl_rise && sda) begin
              state_ff <= I2CCFG_IDLE;
            end else if (scl_fall) begin
              shift_ff  <= rd_byte;
              sda_oe_ff <= ~rd_byte[7];
              state_ff  <= I2CCFG_SEND;
            end
          end
          default: state_ff <= I2CCFG_IDLE;
        endcase
      end
    end
  end

  // working registers, store, lock and power-up copy
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      work_ff[1]  <= MISC_RST;
      work_ff[2]  <= FLOOR_RST;
      work_ff[3]  <= ROOF_RST;
      work_ff[4]  <= ILIM_RST;
      nvm_ff[1]   <= MISC_RST;
      nvm_ff[2]   <= FLOOR_RST;
      nvm_ff[3]   <= ROOF_RST;
      nvm_ff[4]   <= ILIM_RST;
      nvm_ctrl_ff <= NVM_CTRL_RST;
      wp_ff       <= 1'b0;
      load_cnt_ff <= NVM_LOAD_CYCLES;
      off_cnt_ff  <= 4'h0;
    end else begin
      if (off_cnt_ff != 4'h0) begin
        off_cnt_ff <= off_cnt_ff - 4'h1;
      end
      if (load_cnt_ff != 4'h0) begin
        load_cnt_ff <= load_cnt_ff - 4'h1;
        if (load_cnt_ff == 4'h1) begin
          for (int i = 1; i <= 4; i++) begin
            work_ff[i] <= nvm_ff[i];
          end
        end
      end else if (wr_ff.wr) begin
        if (wr_ff.idx == OFS_NVM_CTRL) begin
          if (wr_ff.data == NVM_CMD_SAVE) begin
            if (!wp_ff) begin
              for (int i = 1; i <= 4; i++) begin
                nvm_ff[i] <= work_ff[i];
              end
            end
          end else begin
            nvm_ctrl_ff <= wr_ff.data;
          end
        end else if (wr_ff.idx == OFS_MISC_CONFIG
                     && wr_ff.data[BIT_SOFT_RESET]) begin
          work_ff[1] <= MISC_RST;
          work_ff[2] <= FLOOR_RST;
          work_ff[3] <= ROOF_RST;
          work_ff[4] <= ILIM_RST;
          off_cnt_ff <= CYC_OFF_PULSE;
        end else if (wr_ff.idx >= OFS_MISC_CONFIG
                     && wr_ff.idx <= OFS_ILIM) begin
          if (use_nvm) begin
            if (!wp_ff) begin
              nvm_ff[wr_ff.idx[2:0]] <= wr_ff.data
                                        & wmask(wr_ff.idx, 1'b1);
              if (wr_ff.idx == OFS_ILIM) begin
                wp_ff <= wr_ff.data[BIT_WP];
              end
            end
          end else begin
            work_ff[wr_ff.idx[2:0]] <= wr_ff.data
                                       & wmask(wr_ff.idx, 1'b0);
          end
        end
      end
    end
  end

  function automatic logic [7:0] wmask(input logic [7:0] idx,
                                       input logic       to_nvm);
    logic [7:0] m;
    m = FLOOR_WMASK;
    if (idx == OFS_MISC_CONFIG) m = MISC_WMASK & MISC_NVM_MASK;
    if (idx == OFS_ILIM) m = to_nvm ? (ILIM_WMASK | 8'h80) : ILIM_WMASK;
    return m;
  endfunction

  assign MISC_CONFIG_O           = i2ccfg_misc_t'(work_ff[1]);
  assign BOOST_FLOOR_THRESHOLD_O = work_ff[2];
  assign BOOST_ROOF_THRESHOLD_O  = work_ff[3];
  assign CURRENT_LIMIT_SETUP_O   = work_ff[4];
  assign CONVERTER_OFF_O         = (off_cnt_ff != 4'h0);
  assign HS_MODE_O               = hs_ff;
  assign NVM_LOCKED_O            = wp_ff;
  assign SDA_O                   = 1'b0;
  assign SDA_OE_O                = sda_oe_ff;

  a_hs_clear_stop: assert property (@(posedge CLK_I) disable iff (RST_I)
    stop_ev |=> !hs_ff) else $error("hs mode kept after stop");
  a_ack_only_ack: assert property (@(posedge CLK_I) disable iff (RST_I)
    (state_ff == I2CCFG_ACK) |-> sda_oe_ff) else $error("ack not driven");
  a_lock_no_save: assert property (@(posedge CLK_I) disable iff (RST_I)
    wp_ff |=> $stable(nvm_ff[2])) else $error("locked store changed");
  a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    (idx_ff > OFS_STATUS && idx_ff != OFS_NVM_CTRL) |-> rd_byte == ZERO_BYTE)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    !work_ff[1][4]) else $error("reserved bit set");
  a_reset_pulse: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_ff.wr && wr_ff.idx == OFS_MISC_CONFIG && wr_ff.data[7]
     && load_cnt_ff == 4'h0) |=> CONVERTER_OFF_O [*8])
    else $error("converter off pulse short");
  a_write_on_ack: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_ff.wr |-> $past(state_ff) == I2CCFG_ACK) else $error("late write");
  a_no_hs_ack: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(hs_ff) |-> ##[1:3] !sda_oe_ff) else $error("hs code acked");
  c_write: cover property (@(posedge CLK_I) wr_ff.wr);
  c_read: cover property (@(posedge CLK_I) state_ff == I2CCFG_SEND);
  c_hs: cover property (@(posedge CLK_I) $rose(hs_ff));
endmodule

// ---- logic/i2ccfg_pkg.sv ----
// package: register map, bus constants and carrier types for the config slave
package i2ccfg_pkg;
  localparam logic [4:0] SLV_ADDR_HI     = 5'h1D;
  localparam logic [1:0] SLV_ADDR_LO_DEF = 2'h1;
  localparam logic [4:0] HS_CODE_HI      = 5'h01;
  localparam logic [4:0] REG_IDX_ZERO    = 5'h00;
  localparam logic [7:0] OFS_MISC_CONFIG = 8'h01;
  localparam logic [7:0] OFS_FLOOR       = 8'h02;
  localparam logic [7:0] OFS_ROOF        = 8'h03;
  localparam logic [7:0] OFS_ILIM        = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h05;
  localparam logic [7:0] OFS_NVM_CTRL    = 8'hFF;
  localparam logic [7:0] NVM_CMD_SAVE    = 8'hC0;
  localparam logic [7:0] NVM_SEL_NVM     = 8'hFF;
  localparam logic [7:0] NVM_CTRL_RST    = 8'h00;
  localparam logic [7:0] MISC_RST        = 8'h01;
  localparam logic [7:0] FLOOR_RST       = 8'h06;
  localparam logic [7:0] ROOF_RST        = 8'h0A;
  localparam logic [7:0] ILIM_RST        = 8'h1B;
  localparam logic [7:0] MISC_WMASK      = 8'hEF;
  localparam logic [7:0] MISC_NVM_MASK   = 8'h6F;
  localparam logic [7:0] FLOOR_WMASK     = 8'h1F;
  localparam logic [7:0] ILIM_WMASK      = 8'h3F;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam int         BIT_SOFT_RESET  = 7;
  localparam int         BIT_WP          = 7;
  localparam int         BIT_PIN_FUNC    = 3;
  localparam int         BIT_SPREAD      = 2;
  localparam logic [3:0] NVM_LOAD_CYCLES = 4'h4;
  localparam logic [3:0] CYC_OFF_PULSE   = 4'hF;

  typedef enum logic [1:0] {
    I2CCFG_EN_PINS   = 2'h0,
    I2CCFG_EN_AUTO   = 2'h1,
    I2CCFG_EN_PASS   = 2'h2,
    I2CCFG_EN_SHDN   = 2'h3
  } i2ccfg_enable_t;

  typedef struct packed {
    logic           soft_reset;
    i2ccfg_enable_t enable_sel;
    logic           reserved4;
    logic           shared_pin_function_select;
    logic           spread_spectrum_enable;
    logic [1:0]     switch_mode;
  } i2ccfg_misc_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
  } i2ccfg_wr_t;
endpackage

// ---- logic/i2ccfg_sync.sv ----
// two-stage synchroniser with edge outputs for the bus pins
module i2ccfg_sync (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic pin_i,
  output logic      lvl_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // bus idles high, so every stage resets high
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign lvl_o  = sync_ff;
  assign rise_o = sync_ff & ~last_ff;
  assign fall_o = ~sync_ff & last_ff;
endmodule

// ---- tb/i2ccfg_master.sv ----
// bus master model driving the two-wire bus from the host side
module i2ccfg_master
  import i2ccfg_pkg::*;
(
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime q = 31.25;
  logic    nc;
  // SCL idles high and stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // SDA is released first, so this also makes a repeated start
  task automatic start();
    sda_o = 1'b1;
    #q scl_o = 1'b1;
    #q sda_o = 1'b0;
    #q scl_o = 1'b0;
    #q;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #q scl_o = 1'b1;
    #q sda_o = 1'b1;
    #q;
  endtask
  // lo is set only if SDA stayed low early and late in the high phase
  task automatic slot(input logic b, output logic lo, output logic mid);
    sda_o = b;
    #q scl_o = 1'b1;
    #(q / 2) mid = sda_i;
    #q lo = (mid === 1'b0) && (sda_i === 1'b0);
    #(q / 2) scl_o = 1'b0;
    #q;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      slot(b[i], nc, nc);
    end
    slot(1'b1, ack, nc);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, nc, b[i]);
    end
    slot(nack, nc, nc);
  endtask
  // the caller sends the stop, so the update can be seen before it
  task automatic reg_write(input logic [7:0] sa, idx, dat,
                           output logic ok);
    logic a0, a1, a2;
    start();
    wbyte({sa[7:1], 1'b0}, a0);
    wbyte(idx, a1);
    wbyte(dat, a2);
    ok = a0 & a1 & a2;
  endtask
  task automatic reg_read(input logic [7:0] sa, idx,
                          output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    wbyte({sa[7:1], 1'b0}, a0);
    wbyte(idx, a1);
    start();
    wbyte({sa[7:1], 1'b1}, a2);
    rbyte(1'b1, d);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic hs_enter(output logic ack);
    q = 625.0; // master code at 400 kbit/s
    start();
    wbyte({HS_CODE_HI, 3'h2}, ack);
    q = 31.25;
  endtask
endmodule

// ---- tb/i2ccfg_slave_tb.sv ----
// self-checking bench for the two-wire config slave
module i2ccfg_slave_tb
  import i2ccfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk;
  logic         rst;
  logic [1:0]   strap;
  logic [7:0]   status;
  logic         scl;
  logic         sda_m;
  logic         sda_o;
  logic         sda_oe;
  logic         conv_off;
  logic         hs;
  logic         locked;
  i2ccfg_misc_t misc;
  logic [7:0]   floor_v;
  logic [7:0]   roof_v;
  logic [7:0]   ilim_v;
  logic         ok;
  logic [7:0]   d;
  int           failures;
  int           n_checks;
  int           cyc;
  // pulled-up line: low while either party pulls it
  wire logic    sda_bus = sda_m & ~(sda_oe & ~sda_o);

  i2ccfg_master i_m (.sda_i(sda_bus), .scl_o(scl), .sda_o(sda_m));
  i2ccfg_slave i_dut (
    .CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda_bus),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_STRAP_I(strap),
    .STATUS_FLAGS_I(status), .MISC_CONFIG_O(misc),
    .BOOST_FLOOR_THRESHOLD_O(floor_v), .BOOST_ROOF_THRESHOLD_O(roof_v),
    .CURRENT_LIMIT_SETUP_O(ilim_v), .CONVERTER_OFF_O(conv_off),
    .HS_MODE_O(hs), .NVM_LOCKED_O(locked)
  );

  always #4 clk = ~clk;
  // the full sequence needs about 22000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] sa();
    return {SLV_ADDR_HI, strap, 1'b0};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    i_m.reg_write(sa(), idx, dat, ok);
    chk({7'h00, ok}, 8'h01);
    repeat (8) @(posedge clk);
    i_m.stop();
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    i_m.reg_read(sa(), idx, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask

  task automatic t_reset();
    chk(misc, MISC_RST);
    chk(floor_v, FLOOR_RST);
    chk(roof_v, ROOF_RST);
    chk(ilim_v, ILIM_RST);
    chk({6'h00, hs, locked}, 8'h00);
    rd(OFS_NVM_CTRL, NVM_CTRL_RST);
  endtask
  task automatic t_fields();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, 2'(i), 1'b1, i[0], i[1], 2'(3 - i)};
      i_m.reg_write(sa(), OFS_MISC_CONFIG, v, ok);
      chk({7'h00, ok}, 8'h01);
      repeat (8) @(posedge clk);
      chk(misc, v & MISC_WMASK);
      i_m.stop();
      rd(OFS_MISC_CONFIG, v & MISC_WMASK);
    end
    wr(OFS_FLOOR, 8'hF3);
    chk(floor_v, 8'hF3 & FLOOR_WMASK);
    wr(OFS_ROOF, 8'hEC);
    chk(roof_v, 8'hEC & FLOOR_WMASK);
    wr(OFS_ILIM, 8'hF5);
    chk(ilim_v, 8'hF5 & ILIM_WMASK);
  endtask
  task automatic t_unmapped();
    @(posedge clk);
    status <= 8'h5A;
    rd(OFS_STATUS, 8'h5A);
    rd(8'h00, ZERO_BYTE);
    rd(8'h06, ZERO_BYTE);
    rd(8'h07, ZERO_BYTE);
  endtask
  task automatic t_addr();
    logic ack;
    i_m.start();
    i_m.wbyte({SLV_ADDR_HI, ~strap, 1'b0}, ack);
    i_m.stop();
    chk({7'h00, ack}, 8'h00);
    i_m.start();
    i_m.wbyte(8'h00, ack);
    i_m.stop();
    chk({7'h00, ack}, 8'h00);
    @(posedge clk);
    strap <= 2'h2;
    @(posedge clk);
    rd(OFS_STATUS, 8'h5A);
  endtask
  task automatic t_hs();
    logic ack;
    i_m.hs_enter(ack);
    chk({7'h00, ack}, 8'h00);
    chk({7'h00, hs}, 8'h01);
    i_m.reg_write(sa(), OFS_ROOF, 8'h0B, ok);
    chk({7'h00, ok & hs}, 8'h01);
    i_m.stop();
    repeat (8) @(posedge clk);
    chk(roof_v, 8'h0B);
    chk({7'h00, hs}, 8'h00);
  endtask
  task automatic t_nvm();
    wr(OFS_FLOOR, 8'h11);
    wr(OFS_NVM_CTRL, NVM_CMD_SAVE);
    wr(OFS_FLOOR, 8'h05);
    wr(OFS_NVM_CTRL, NVM_SEL_NVM);
    rd(OFS_FLOOR, 8'h11);
    chk(floor_v, 8'h05);
    wr(OFS_NVM_CTRL, NVM_CTRL_RST);
    rd(OFS_FLOOR, 8'h05);
  endtask
  task automatic t_soft();
    int n;
    n = 0;
    fork
      i_m.reg_write(sa(), OFS_MISC_CONFIG, 8'hA5, ok);
      repeat (800) @(posedge clk) n += int'(conv_off === 1'b1);
    join
    i_m.stop();
    chk(8'(n), {4'h0, CYC_OFF_PULSE});
    chk(misc, MISC_RST);
    chk(floor_v, FLOOR_RST);
  endtask
  // the lock is one-way, so this runs last
  task automatic t_lock();
    wr(OFS_NVM_CTRL, NVM_SEL_NVM);
    wr(OFS_ILIM, 8'h9B);
    chk({7'h00, locked}, 8'h01);
    wr(OFS_FLOOR, 8'h07);
    rd(OFS_FLOOR, 8'h11);
    wr(OFS_NVM_CTRL, NVM_CTRL_RST);
    wr(OFS_FLOOR, 8'h09);
    wr(OFS_NVM_CTRL, NVM_CMD_SAVE);
    wr(OFS_NVM_CTRL, NVM_SEL_NVM);
    rd(OFS_FLOOR, 8'h11);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    strap = SLV_ADDR_LO_DEF;
    status = 8'h00;
    failures = 0;
    n_checks = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    i_m.stop();
    t_reset();
    t_fields();
    t_unmapped();
    t_addr();
    t_hs();
    t_nvm();
    t_soft();
    t_lock();
    report_and_stop();
  end
endmodule
